// [include/lpr_pkg.sv]
// Purpose: Shared constants and types of the lookup-table pixel remapper
// Assumes: 16-bit 5-6-5 pixels, byte-addressed memory
// Notes:   Used by the remapper top and its FIFO
package lpr_pkg;
   // ------------------------------------------------------------
   // Lookup word layout
   // ------------------------------------------------------------
   localparam int LPR_WORD_W    = 32;
   localparam int LPR_CODE_HI   = 31;
   localparam int LPR_CODE_LO   = 30;
   localparam int LPR_CAM_HI    = 29;
   localparam int LPR_CAM_LO    = 28;
   localparam int LPR_OFS_HI    = 27;
   localparam int LPR_OFS_LO    = 0;
   localparam int LPR_OFS_W     = LPR_OFS_HI - LPR_OFS_LO + 1;
   localparam int LPR_NUM_CAMS  = 4;

   // ------------------------------------------------------------
   // Pixel format and addressing
   // ------------------------------------------------------------
   localparam int LPR_PIX_W     = 16;
   localparam int LPR_ADDR_W    = 32;
   localparam int LPR_LEN_W     = 28;
   localparam int LPR_PIX_SHIFT = 1;
   localparam int LPR_WORD_SHIFT = 2;
   localparam int LPR_R_HI      = 15;
   localparam int LPR_R_LO      = 11;
   localparam int LPR_G_HI      = 10;
   localparam int LPR_G_LO      = 5;
   localparam int LPR_B_HI      = 4;
   localparam int LPR_B_LO      = 0;
   localparam int LPR_FIFO_DEPTH = 8;

   // ------------------------------------------------------------
   // Interpolation codes
   // ------------------------------------------------------------
   localparam logic [1:0] LPR_CODE_NONE = 2'h0;
   localparam logic [1:0] LPR_CODE_VERT = 2'h1;
   localparam logic [1:0] LPR_CODE_HORZ = 2'h2;
   localparam logic [1:0] LPR_CODE_QUAD = 2'h3;

   typedef enum logic [1:0] {LPR_DEC_IDLE, LPR_DEC_FETCH, LPR_DEC_PUSH} lpr_dec_type;
endpackage : lpr_pkg

// [include/lpr_fifo_if.sv]
// Purpose: Valid/ready carrier between the remapper and one of its FIFOs
// Assumes: One clock shared by both sides
// Notes:   level counts stored words
interface lpr_fifo_if #(
   parameter int W     = 32,
   parameter int LVL_W = 4
) ();
   logic             push_valid;
   logic             push_ready;
   logic [W-1:0]     push_data;
   logic             pop_valid;
   logic             pop_ready;
   logic [W-1:0]     pop_data;
   logic [LVL_W-1:0] level;

   modport store    (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data, level);
   modport producer (output push_valid, push_data, input push_ready, level);
   modport consumer (output pop_ready, input pop_valid, pop_data);
endinterface : lpr_fifo_if

// [hdl/lpr_fifo.sv]
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two, at least 2
// Notes:   pop_data comes straight from the storage flops
module lpr_fifo
   import lpr_pkg::*;
#(
   parameter int W     = 32,
   parameter int DEPTH = LPR_FIFO_DEPTH,
   parameter int LVL_W = 4
) (
   input  wire logic   clk_in,
   input  wire logic   rst_in,
   lpr_fifo_if.store   port
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || LVL_W < AW + 1 || port.W != W)
      $error("lpr_fifo: unsupported DEPTH, LVL_W or width");

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           rd;
      logic [AW-1:0]           wr;
      logic [AW:0]             cnt;
   } lpr_fifo_st_type;

   lpr_fifo_st_type st;
   lpr_fifo_st_type next_st;
   logic            do_push;
   logic            do_pop;

   assign port.push_ready = (st.cnt != (AW+1)'(DEPTH));
   assign port.pop_valid  = (st.cnt != '0);
   assign port.pop_data   = st.mem[st.rd];
   assign port.level      = LVL_W'(st.cnt);

   always_comb begin
      next_st = st;
      do_push = port.push_valid & port.push_ready;
      do_pop  = port.pop_ready & port.pop_valid;
      if (do_push) begin
         next_st.mem[st.wr] = port.push_data;
         next_st.wr         = st.wr + 1'b1;
      end
      if (do_pop) begin
         next_st.rd = st.rd + 1'b1;
      end
      if (do_push && !do_pop) begin
         next_st.cnt = st.cnt + 1'b1;
      end else if (do_pop && !do_push) begin
         next_st.cnt = st.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule : lpr_fifo

// [hdl/lpr_remapper.sv]
// Purpose: Table-driven pixel remapper: table reader, decoder/interpolator, pixel writer
// Assumes: Bus inputs are on REF_CLK_IN; configuration ports stay stable during a run
// Notes:   Bases are byte addresses; offsets and pitch count pixels
// Behaviour
// - Read lookup words in order from consecutive addresses, push them unchanged.
// - Table reads are pipelined with several outstanding.
// - Split word into code 31:30, camera 29:28, offset 27:0.
// - Four camera base pointers; camera field picks one.
// - Source address is camera base plus offset, in pixel units.
// - Code 0 outputs the single pixel unchanged.
// - Code 1 averages pixel and one row below; code 2 with right neighbour.
// - Code 3 averages four pixels of a two by two square.
// - Pixels are 16-bit 5-6-5; addresses step by one pixel.
// - Each computed pixel is pushed into the output FIFO.
// - Pixel reads are pipelined and fetch exactly one, two or four pixels.
// - The code of each word sets its number of pixel reads.
// - Writer pops output pixels and stores them at consecutive addresses.
// - One lookup word is consumed for each pixel written.
// - Control ports set up and start the engine.
module lpr_remapper
   import lpr_pkg::*;
#(
   parameter int FIFO_DEPTH = LPR_FIFO_DEPTH
) (
   input  wire logic                                    REF_CLK_IN,
   input  wire logic                                    SRST_IN,
   input  wire logic                                    START_IN,
   input  wire logic [LPR_ADDR_W-1:0]                   TBL_BASE_IN,
   input  wire logic [LPR_LEN_W-1:0]                    TBL_LEN_IN,
   input  wire logic [LPR_NUM_CAMS-1:0][LPR_ADDR_W-1:0] CAM_BASE_IN,
   input  wire logic [LPR_OFS_W-1:0]                    PITCH_IN,
   input  wire logic [LPR_ADDR_W-1:0]                   DISP_BASE_IN,
   output      logic                                    BUSY_OUT,
   output      logic                                    DONE_OUT,
   output      logic [LPR_ADDR_W-1:0]                   TBL_ADDR_OUT,
   output      logic                                    TBL_READ_OUT,
   input  wire logic                                    TBL_WAIT_IN,
   input  wire logic                                    TBL_RVALID_IN,
   input  wire logic [LPR_WORD_W-1:0]                   TBL_RDATA_IN,
   output      logic [LPR_ADDR_W-1:0]                   PIX_ADDR_OUT,
   output      logic                                    PIX_READ_OUT,
   input  wire logic                                    PIX_WAIT_IN,
   input  wire logic                                    PIX_RVALID_IN,
   input  wire logic [LPR_PIX_W-1:0]                    PIX_RDATA_IN,
   output      logic [LPR_ADDR_W-1:0]                   WR_ADDR_OUT,
   output      logic                                    WR_WRITE_OUT,
   output      logic [LPR_PIX_W-1:0]                    WR_DATA_OUT,
   input  wire logic                                    WR_WAIT_IN
);
   // Level spans 0..DEPTH, one bit over the address
   localparam int LVL_W = $clog2(FIFO_DEPTH + 1);
   localparam int CNT_W = LVL_W + 2;

   if (FIFO_DEPTH < 2 || FIFO_DEPTH > 64)
      $error("lpr_remapper: FIFO_DEPTH out of range");

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Source reads per interpolation code
   function automatic logic [2:0] pix_count(input logic [1:0] code);
      case (code)
         LPR_CODE_NONE: pix_count = 3'h1;
         LPR_CODE_QUAD: pix_count = 3'h4;
         default:       pix_count = 3'h2;
      endcase
   endfunction : pix_count

   // Step of read k: bit 0 right (down for code 1), bit 1 down
   function automatic logic [LPR_OFS_W-1:0] pix_delta(input logic [1:0] code, input logic [1:0] k,
                                                      input logic [LPR_OFS_W-1:0] pitch);
      logic horz;
      logic vert;
      horz = ((code == LPR_CODE_HORZ) || (code == LPR_CODE_QUAD)) && k[0];
      vert = (code == LPR_CODE_VERT) ? k[0] : ((code == LPR_CODE_QUAD) && k[1]);
      pix_delta = (vert ? pitch : '0) + (horz ? LPR_OFS_W'(1) : '0);
   endfunction : pix_delta

   // Offset wraps in 28 bits before scaling; the table must not point past that range
   function automatic logic [LPR_ADDR_W-1:0] fetch_source_pixel(input logic [LPR_ADDR_W-1:0] base,
                                                                input logic [LPR_OFS_W-1:0]  ofs,
                                                                input logic [LPR_OFS_W-1:0]  delta);
      logic [LPR_OFS_W-1:0] pix;
      pix = ofs + delta;
      fetch_source_pixel = base + (LPR_ADDR_W'(pix) << LPR_PIX_SHIFT);
   endfunction : fetch_source_pixel

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      // Frame control
      logic                  running;
      logic                  done;

      // Table reader
      logic [LPR_LEN_W-1:0]  tbl_issued;
      logic [CNT_W-1:0]      tbl_outst;
      logic                  tbl_read;
      logic [LPR_ADDR_W-1:0] tbl_addr;

      // Decoder
      lpr_dec_type           dec;
      logic [1:0]            code;
      logic [1:0]            cam;
      logic [LPR_OFS_W-1:0]  ofs;
      logic [2:0]            k_issued;
      logic [2:0]            k_recv;

      // Pixel reader
      logic                  pix_read;
      logic [LPR_ADDR_W-1:0] pix_addr;

      // Channel sums, room for four pixels
      logic [6:0]            sum_r;
      logic [7:0]            sum_g;
      logic [6:0]            sum_b;
      logic [LPR_PIX_W-1:0]  result;

      // Pixel writer
      logic [LPR_LEN_W-1:0]  wr_count;
      logic                  wr_write;
      logic [LPR_ADDR_W-1:0] wr_addr;
      logic [LPR_PIX_W-1:0]  wr_data;
   } lpr_st_type;

   lpr_st_type st;
   lpr_st_type next_st;

   // Table words and output pixels each pass their own FIFO
   lpr_fifo_if #(.W(LPR_WORD_W), .LVL_W(LVL_W)) tbl_q ();
   lpr_fifo_if #(.W(LPR_PIX_W),  .LVL_W(LVL_W)) out_q ();

   lpr_fifo #(.W(LPR_WORD_W), .DEPTH(FIFO_DEPTH), .LVL_W(LVL_W)) u_tbl_fifo (
      .clk_in (REF_CLK_IN),
      .rst_in (SRST_IN),
      .port   (tbl_q)
   );

   lpr_fifo #(.W(LPR_PIX_W), .DEPTH(FIFO_DEPTH), .LVL_W(LVL_W)) u_out_fifo (
      .clk_in (REF_CLK_IN),
      .rst_in (SRST_IN),
      .port   (out_q)
   );

   logic                  tbl_accept;
   logic                  pix_accept;
   logic                  wr_accept;
   logic [CNT_W-1:0]      tbl_credit;
   logic [2:0]            n_pix;
   logic [2:0]            k_recv_next;
   logic [LPR_WORD_W-1:0] word;

   // Taken on an edge with wait low
   assign tbl_accept  = st.tbl_read & ~TBL_WAIT_IN;
   assign pix_accept  = st.pix_read & ~PIX_WAIT_IN;
   assign wr_accept   = st.wr_write & ~WR_WAIT_IN;
   assign n_pix       = pix_count(st.code);
   assign tbl_credit  = CNT_W'(tbl_q.level) + st.tbl_outst + CNT_W'(st.tbl_read);
   assign word        = tbl_q.pop_data;

   // Words arrive only for reads already covered by free FIFO space
   assign tbl_q.push_valid = TBL_RVALID_IN;
   assign tbl_q.push_data  = TBL_RDATA_IN;
   assign tbl_q.pop_ready  = st.running && (st.dec == LPR_DEC_IDLE);
   assign out_q.push_valid = (st.dec == LPR_DEC_PUSH);
   assign out_q.push_data  = st.result;
   assign out_q.pop_ready  = st.running && (!st.wr_write || wr_accept);

   assign BUSY_OUT     = st.running;
   assign DONE_OUT     = st.done;
   assign TBL_ADDR_OUT = st.tbl_addr;
   assign TBL_READ_OUT = st.tbl_read;
   assign PIX_ADDR_OUT = st.pix_addr;
   assign PIX_READ_OUT = st.pix_read;
   assign WR_ADDR_OUT  = st.wr_addr;
   assign WR_WRITE_OUT = st.wr_write;
   assign WR_DATA_OUT  = st.wr_data;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_st      = st;
      next_st.done = 1'b0;
      k_recv_next  = st.k_recv;

      // A start during a frame is ignored
      if (!st.running) begin
         if (START_IN) begin
            next_st.running    = 1'b1;
            next_st.tbl_issued = '0;
            next_st.wr_count   = '0;
            next_st.dec        = LPR_DEC_IDLE;
         end
      end else begin
         // Table reader: a new read only while the FIFO can take every word in flight
         next_st.tbl_outst = st.tbl_outst + CNT_W'(tbl_accept) - CNT_W'(TBL_RVALID_IN);

         if (!st.tbl_read || tbl_accept) begin
            if (st.tbl_issued != TBL_LEN_IN && tbl_credit < CNT_W'(FIFO_DEPTH)) begin
               next_st.tbl_read   = 1'b1;
               next_st.tbl_addr   = TBL_BASE_IN + (LPR_ADDR_W'(st.tbl_issued) << LPR_WORD_SHIFT);
               next_st.tbl_issued = st.tbl_issued + 1'b1;
            end else begin
               next_st.tbl_read = 1'b0;
            end
         end

         // Decoder and interpolator
         case (st.dec)
            LPR_DEC_IDLE: begin
               if (tbl_q.pop_valid) begin
                  next_st.code     = word[LPR_CODE_HI:LPR_CODE_LO];
                  next_st.cam      = word[LPR_CAM_HI:LPR_CAM_LO];
                  next_st.ofs      = word[LPR_OFS_HI:LPR_OFS_LO];
                  // Fresh counts per word
                  next_st.k_issued = '0;
                  next_st.k_recv   = '0;
                  next_st.sum_r    = '0;
                  next_st.sum_g    = '0;
                  next_st.sum_b    = '0;
                  next_st.dec      = LPR_DEC_FETCH;
               end
            end

            LPR_DEC_FETCH: begin
               if (!st.pix_read || pix_accept) begin
                  if (st.k_issued != n_pix) begin
                     next_st.pix_read = 1'b1;
                     next_st.pix_addr = fetch_source_pixel(CAM_BASE_IN[st.cam], st.ofs,
                                           pix_delta(st.code, st.k_issued[1:0], PITCH_IN));
                     next_st.k_issued = st.k_issued + 1'b1;
                  end else begin
                     next_st.pix_read = 1'b0;
                  end
               end

               if (PIX_RVALID_IN) begin
                  // Channels summed apart so a carry never crosses from blue into green
                  next_st.sum_r = st.sum_r + 7'(PIX_RDATA_IN[LPR_R_HI:LPR_R_LO]);
                  next_st.sum_g = st.sum_g + 8'(PIX_RDATA_IN[LPR_G_HI:LPR_G_LO]);
                  next_st.sum_b = st.sum_b + 7'(PIX_RDATA_IN[LPR_B_HI:LPR_B_LO]);
                  k_recv_next   = st.k_recv + 1'b1;
               end
               next_st.k_recv = k_recv_next;

               // Divide by 1, 2 or 4: a shift that truncates
               if (k_recv_next == n_pix) begin
                  case (st.code)
                     LPR_CODE_NONE: next_st.result = {next_st.sum_r[4:0], next_st.sum_g[5:0],
                                                      next_st.sum_b[4:0]};
                     LPR_CODE_QUAD: next_st.result = {next_st.sum_r[6:2], next_st.sum_g[7:2],
                                                      next_st.sum_b[6:2]};
                     default:       next_st.result = {next_st.sum_r[5:1], next_st.sum_g[6:1],
                                                      next_st.sum_b[5:1]};
                  endcase
                  next_st.dec = LPR_DEC_PUSH;
               end
            end

            // Stays until the FIFO has room
            LPR_DEC_PUSH: begin
               if (out_q.push_ready) begin
                  next_st.dec = LPR_DEC_IDLE;
               end
            end

            default: begin
               next_st.dec = LPR_DEC_IDLE;
            end
         endcase

         // Pixel writer
         // A held write blocks the next pop
         if (!st.wr_write || wr_accept) begin
            if (out_q.pop_valid) begin
               next_st.wr_write = 1'b1;
               next_st.wr_addr  = DISP_BASE_IN + (LPR_ADDR_W'(st.wr_count) << LPR_PIX_SHIFT);
               next_st.wr_data  = out_q.pop_data;
               next_st.wr_count = st.wr_count + 1'b1;
            end else begin
               next_st.wr_write = 1'b0;
            end
         end

         // Frame ends once the last pixel write has been taken
         if (st.wr_count == TBL_LEN_IN && !next_st.wr_write && st.dec == LPR_DEC_IDLE) begin
            next_st.running = 1'b0;
            next_st.done    = 1'b1;
         end
      end
   end

   // Reset clears all requests and counts
   always_ff @(posedge REF_CLK_IN) begin
      if (SRST_IN) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule : lpr_remapper

// [tb/lpr_remapper_assertions.sv]
// Purpose: Port-level checks of the pixel remapper
// Assumes: One clock, sync reset; memory answers only accepted reads
// Notes:   Bound into every lpr_remapper instance
module lpr_checker
   import lpr_pkg::*;
#(
   parameter int FIFO_DEPTH = LPR_FIFO_DEPTH
) (
   input wire logic                  REF_CLK_IN,
   input wire logic                  SRST_IN,
   input wire logic                  START_IN,
   input wire logic [LPR_ADDR_W-1:0] TBL_BASE_IN,
   input wire logic [LPR_ADDR_W-1:0] DISP_BASE_IN,
   input wire logic                  BUSY_OUT,
   input wire logic                  DONE_OUT,
   input wire logic [LPR_ADDR_W-1:0] TBL_ADDR_OUT,
   input wire logic                  TBL_READ_OUT,
   input wire logic                  TBL_WAIT_IN,
   input wire logic                  TBL_RVALID_IN,
   input wire logic [LPR_ADDR_W-1:0] PIX_ADDR_OUT,
   input wire logic                  PIX_READ_OUT,
   input wire logic                  PIX_WAIT_IN,
   input wire logic [LPR_ADDR_W-1:0] WR_ADDR_OUT,
   input wire logic                  WR_WRITE_OUT,
   input wire logic [LPR_PIX_W-1:0]  WR_DATA_OUT,
   input wire logic                  WR_WAIT_IN
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----
   // Helpers: last accepted addresses, table reads in flight
   // ----
   logic                  tbl_seen, wr_seen;
   logic [LPR_ADDR_W-1:0] tbl_last, wr_last;
   logic [7:0]            tbl_outs;
   always_ff @(posedge REF_CLK_IN) begin
      if (SRST_IN || (START_IN && !BUSY_OUT)) begin
         tbl_seen <= 1'b0;
         wr_seen  <= 1'b0;
      end else begin
         if (TBL_READ_OUT && !TBL_WAIT_IN) begin
            tbl_seen <= 1'b1;
            tbl_last <= TBL_ADDR_OUT;
         end
         if (WR_WRITE_OUT && !WR_WAIT_IN) begin
            wr_seen <= 1'b1;
            wr_last <= WR_ADDR_OUT;
         end
      end
      if (SRST_IN) tbl_outs <= 8'h00;
      else tbl_outs <= tbl_outs + 8'(TBL_READ_OUT && !TBL_WAIT_IN) - 8'(TBL_RVALID_IN);
   end
   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (SRST_IN);
   // ----
   // Assertions
   // ----
   a_tbl_order:  assert property (TBL_READ_OUT |-> TBL_ADDR_OUT == (tbl_seen ? tbl_last + 32'h4 : TBL_BASE_IN))
      else $error("table read address out of sequence");
   a_tbl_hold:   assert property (TBL_READ_OUT && TBL_WAIT_IN |=> TBL_READ_OUT && $stable(TBL_ADDR_OUT))
      else $error("table read dropped during wait");
   a_tbl_credit: assert property (tbl_outs <= FIFO_DEPTH)
      else $error("more table reads in flight than fifo room");
   a_pix_hold:   assert property (PIX_READ_OUT && PIX_WAIT_IN |=> PIX_READ_OUT && $stable(PIX_ADDR_OUT))
      else $error("pixel read dropped during wait");
   a_wr_order:   assert property (WR_WRITE_OUT |-> WR_ADDR_OUT == (wr_seen ? wr_last + 32'h2 : DISP_BASE_IN))
      else $error("write address out of sequence");
   a_wr_hold:    assert property (WR_WRITE_OUT && WR_WAIT_IN |=> WR_WRITE_OUT && $stable({WR_ADDR_OUT, WR_DATA_OUT}))
      else $error("write changed during wait");
   a_start_busy: assert property (START_IN && !BUSY_OUT |=> BUSY_OUT)
      else $error("start not taken");
   a_done_fall:  assert property ($fell(BUSY_OUT) && !$past(SRST_IN) |-> DONE_OUT ##1 !DONE_OUT)
      else $error("done pulse missing at frame end");
   a_idle_quiet: assert property (!BUSY_OUT |-> !TBL_READ_OUT && !PIX_READ_OUT && !WR_WRITE_OUT)
      else $error("bus request while idle");
   c_done:      cover property (DONE_OUT);
   c_wr_stall:  cover property (WR_WRITE_OUT && WR_WAIT_IN);
   c_tbl_burst: cover property (TBL_READ_OUT && !TBL_WAIT_IN ##1 TBL_READ_OUT && !TBL_WAIT_IN);
endmodule : lpr_checker

bind lpr_remapper lpr_checker #(.FIFO_DEPTH(FIFO_DEPTH)) lpr_checker_inst (.REF_CLK_IN, .SRST_IN, .START_IN,
   .TBL_BASE_IN, .DISP_BASE_IN, .BUSY_OUT, .DONE_OUT, .TBL_ADDR_OUT, .TBL_READ_OUT, .TBL_WAIT_IN, .TBL_RVALID_IN,
   .PIX_ADDR_OUT, .PIX_READ_OUT, .PIX_WAIT_IN, .WR_ADDR_OUT, .WR_WRITE_OUT, .WR_DATA_OUT, .WR_WAIT_IN);

// [tb/lpr_mem_model.sv]
// Purpose: Frame memory behind the three remapper masters
// Assumes: Read latency two cycles, in order
// Notes:   Logs every accepted request for the bench to compare
module lpr_mem_model (
   input  wire logic        clk_in,
   input  wire logic        srst_in,
   input  wire logic        stall_in,
   input  wire logic [31:0] tbl_addr_in,
   input  wire logic        tbl_read_in,
   output      logic        tbl_wait_out,
   output      logic        tbl_rvalid_out,
   output      logic [31:0] tbl_rdata_out,
   input  wire logic [31:0] pix_addr_in,
   input  wire logic        pix_read_in,
   output      logic        pix_wait_out,
   output      logic        pix_rvalid_out,
   output      logic [15:0] pix_rdata_out,
   input  wire logic [31:0] wr_addr_in,
   input  wire logic        wr_write_in,
   input  wire logic [15:0] wr_data_in,
   output      logic        wr_wait_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] tbl [0:15];
   logic [31:0] tbl_aq[$], pix_aq[$], wr_aq[$];
   logic [15:0] wr_dq[$];
   logic [2:0]  cnt = 3'h0;
   logic        ta, pa;
   logic [31:0] td;
   logic [15:0] pd;
   // Pixel side is stalled less often than the table side
   assign tbl_wait_out = stall_in & cnt[0];
   assign pix_wait_out = stall_in & (cnt[1:0] == 2'h3);
   assign wr_wait_out  = stall_in & (cnt != 3'h0);
   always @(posedge clk_in) begin
      cnt <= cnt + 3'h1;
      ta  <= tbl_read_in & ~tbl_wait_out & ~srst_in;
      pa  <= pix_read_in & ~pix_wait_out & ~srst_in;
      td  <= tbl[tbl_addr_in[5:2]];
      pd  <= pix_addr_in[16:1] ^ pix_addr_in[31:16];
      tbl_rvalid_out <= ta & ~srst_in;
      pix_rvalid_out <= pa & ~srst_in;
      // Idle data lines flip so stale values are never mistaken for fresh ones
      tbl_rdata_out <= srst_in ? 32'h0 : (ta ? td : ~tbl_rdata_out);
      pix_rdata_out <= srst_in ? 16'h0 : (pa ? pd : ~pix_rdata_out);
      if (tbl_read_in && !tbl_wait_out) tbl_aq.push_back(tbl_addr_in);
      if (pix_read_in && !pix_wait_out) pix_aq.push_back(pix_addr_in);
      if (wr_write_in && !wr_wait_out) begin
         wr_aq.push_back(wr_addr_in);
         wr_dq.push_back(wr_data_in);
      end
   end
endmodule : lpr_mem_model

// [tb/testbench.sv]
// Purpose: Frame-level test of the pixel remapper against a memory model
// Assumes: Memory model answers with fixed latency, optional stalls
// Notes:   Expected pixels are rebuilt here from the lookup words
module testbench
   import lpr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0, srst = 1'b1, start = 1'b0, stall = 1'b0;
   logic [31:0] tbl_base = 32'h0000_4000, disp_base = 32'h0080_0000;
   logic [27:0] tbl_len = 28'h0, pitch = 28'h140;
   logic [3:0][31:0] cam_base = {32'h0040_0000, 32'h0030_0000, 32'h0020_0000, 32'h0010_0000};
   logic busy, done, tr, tw, tv, pr, pw, pv, ww, wwt;
   logic [31:0] ta, td, pa, wa;
   logic [15:0] pd, wd;
   int num_errors = 0, checks = 0, cycles = 0;
   logic [31:0] exp_pa[$];
   logic [15:0] exp_px[$];
   always #5 ref_clk = ~ref_clk;
   lpr_remapper lpr_remapper_inst (.REF_CLK_IN(ref_clk), .SRST_IN(srst), .START_IN(start), .TBL_BASE_IN(tbl_base),
      .TBL_LEN_IN(tbl_len), .CAM_BASE_IN(cam_base), .PITCH_IN(pitch), .DISP_BASE_IN(disp_base), .BUSY_OUT(busy),
      .DONE_OUT(done), .TBL_ADDR_OUT(ta), .TBL_READ_OUT(tr), .TBL_WAIT_IN(tw), .TBL_RVALID_IN(tv),
      .TBL_RDATA_IN(td), .PIX_ADDR_OUT(pa), .PIX_READ_OUT(pr), .PIX_WAIT_IN(pw), .PIX_RVALID_IN(pv),
      .PIX_RDATA_IN(pd), .WR_ADDR_OUT(wa), .WR_WRITE_OUT(ww), .WR_DATA_OUT(wd), .WR_WAIT_IN(wwt));
   lpr_mem_model lpr_mem_model_inst (.clk_in(ref_clk), .srst_in(srst), .stall_in(stall), .tbl_addr_in(ta),
      .tbl_read_in(tr), .tbl_wait_out(tw), .tbl_rvalid_out(tv), .tbl_rdata_out(td), .pix_addr_in(pa),
      .pix_read_in(pr), .pix_wait_out(pw), .pix_rvalid_out(pv), .pix_rdata_out(pd), .wr_addr_in(wa),
      .wr_write_in(ww), .wr_data_in(wd), .wr_wait_out(wwt));
   // ----
   // Tasks
   // ----
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop();
      $display("num_errors=%0d checks=%0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop
   // Reads in the order code 0..3 asks for, then the floored channel mean
   task automatic build(input logic [31:0] w);
      logic [27:0] d;
      logic [31:0] a;
      logic [15:0] p;
      logic [7:0]  r, g, b;
      int          n;
      n = (w[31:30] == LPR_CODE_NONE) ? 1 : (w[31:30] == LPR_CODE_QUAD) ? 4 : 2;
      r = 8'h0; g = 8'h0; b = 8'h0;
      for (int j = 0; j < n; j++) begin
         d = ((w[31:30] == LPR_CODE_VERT && j == 1) || j > 1) ? pitch : 28'h0;
         if (w[31:30] != LPR_CODE_VERT && j % 2 == 1) d = d + 28'h1;
         a = cam_base[w[29:28]] + {3'h0, w[27:0] + d, 1'b0};
         exp_pa.push_back(a);
         p = a[16:1] ^ a[31:16];
         r += 8'(p[15:11]); g += 8'(p[10:5]); b += 8'(p[4:0]);
      end
      exp_px.push_back({5'(r / n), 6'(g / n), 5'(b / n)});
   endtask : build
   task automatic run_frame(input logic [27:0] len, input logic st);
      int k;
      exp_pa.delete(); exp_px.delete();
      lpr_mem_model_inst.tbl_aq.delete(); lpr_mem_model_inst.pix_aq.delete();
      lpr_mem_model_inst.wr_aq.delete(); lpr_mem_model_inst.wr_dq.delete();
      for (int i = 0; i < len; i++) build(lpr_mem_model_inst.tbl[i]);
      @(posedge ref_clk);
      start <= 1'b1; stall <= st; tbl_len <= len;
      @(posedge ref_clk);
      start <= 1'b0;
      @(negedge ref_clk);
      check(32'(busy), 32'h1);
      if (len != 0) begin
         // Second start while running must be ignored
         @(posedge ref_clk); start <= 1'b1;
         @(posedge ref_clk); start <= 1'b0;
         @(negedge ref_clk);
      end
      k = 0;
      while (done !== 1'b1 && k < 3000) begin
         @(negedge ref_clk);
         k++;
      end
      check(32'(done), 32'h1);
      repeat (3) @(negedge ref_clk);
      check(32'(busy), 32'h0);
      check(32'(lpr_mem_model_inst.wr_aq.size()), 32'(len));
      check(32'(lpr_mem_model_inst.tbl_aq.size()), 32'(len));
      for (int i = 0; i < lpr_mem_model_inst.wr_aq.size() && i < len; i++) begin
         check(lpr_mem_model_inst.tbl_aq[i], tbl_base + 32'(4 * i));
         check(lpr_mem_model_inst.wr_aq[i], disp_base + 32'(2 * i));
         check(32'(lpr_mem_model_inst.wr_dq[i]), 32'(exp_px[i]));
      end
      check(32'(lpr_mem_model_inst.pix_aq.size()), 32'(exp_pa.size()));
      for (int i = 0; i < exp_pa.size() && i < lpr_mem_model_inst.pix_aq.size(); i++)
         check(lpr_mem_model_inst.pix_aq[i], exp_pa[i]);
   endtask : run_frame
   // ----
   // Sequence
   // ----
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end
   initial begin
      for (int i = 0; i < 16; i++)
         lpr_mem_model_inst.tbl[i] = {2'(i % 4), 2'((i + i / 4) % 4), 28'(32'h100 * i + 3)};
      // Offset at the top of the field wraps in the neighbour reads
      lpr_mem_model_inst.tbl[9] = {2'h3, 2'h1, 28'hfffffff};
      repeat (5) @(posedge ref_clk);
      srst <= 1'b0;
      run_frame(28'd10, 1'b0);
      run_frame(28'd10, 1'b1);
      run_frame(28'd0, 1'b0);
      report_and_stop();
   end
endmodule : testbench
